// File: core/apt_pkg.sv
// Purpose: shared constants and types for the 8-bit phase-correct PWM timer
// Assumes: AHB-Lite register access, one 32-bit aligned word per register
// Notes:   all offsets are byte addresses
package apt_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNT   = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_ASYNC   = 8'h0C;
  localparam logic [7:0] OFF_FLAGS   = 8'h10;

  // ==========================================================================
  // field positions
  localparam int BIT_ASYNC_SEL   = 3;
  localparam int BIT_COUNT_BUSY  = 2;
  localparam int BIT_CMP_BUSY    = 1;
  localparam int BIT_CTRL_BUSY   = 0;
  localparam int BIT_CMP_FLAG    = 1;
  localparam int BIT_OVF_FLAG    = 0;

  // holding stage index per asynchronously written register
  localparam int HOLD_CTRL  = 0;
  localparam int HOLD_CMP   = 1;
  localparam int HOLD_COUNT = 2;

  // ==========================================================================
  // values
  localparam logic [7:0] CNT_MAX       = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM    = 8'h00;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [1:0] WGM_PHASE_COR = 2'h1;
  localparam logic [1:0] COM_OFF       = 2'h0;
  localparam logic [1:0] COM_NONINV    = 2'h2;
  localparam logic [1:0] COM_INV       = 2'h3;
  localparam logic [1:0] XFER_EDGES    = 2'h2;  // crystal edges per transfer
  localparam int         FLAG_SYNC_CYC = 3;     // processor cycles of flag sync

  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_1    = 3'h1;
  localparam logic [2:0] CS_8    = 3'h2;
  localparam logic [2:0] CS_32   = 3'h3;
  localparam logic [2:0] CS_64   = 3'h4;
  localparam logic [2:0] CS_128  = 3'h5;
  localparam logic [2:0] CS_256  = 3'h6;
  localparam logic [2:0] CS_1024 = 3'h7;

  // ==========================================================================
  // types
  typedef struct packed {
    logic       force_cmp;  // dropped on write, reads as zero
    logic       wgm0;
    logic [1:0] com;
    logic       wgm1;
    logic [2:0] cs;
  } apt_ctrl_s;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } apt_dir_e;

endpackage

// File: core/apt_timer.sv
// Purpose: 8-bit timer with dual-slope phase-correct PWM and crystal clocking
// Assumes: inputs synchronous to mclk; mclk well above four crystal rates
// Notes:   crystal edges act as enables, the whole block runs on mclk
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - mode one counts up then down forever
// - clear on up match, set on down
// - output mode two normal, three inverted
// - resolution fixed at eight bits
// - counter stays at MAX one tick
// - overflow flag set at BOTTOM
// - compare BOTTOM low, MAX high output
// - leaving MAX gives up-match level at MAX
// - missed up match still corrected at MAX
// - period 510 ticks, seven prescale factors
// - timer tick is a clock enable
// - async writes commit after two crystal edges
// - control, compare and count each have own holding stage
// - busy flag per pending register transfer
// - no compare match while count or compare write pending
// - wake logic rearms after one crystal cycle
// - deep wake leaves registers at defaults
// - wake starts on next timer tick
// - counter read through crystal-edge copy
// - async flags delayed three processor cycles
// - maximum count is 0xFF
// - async select clocks from crystal input
// - output mode zero leaves pin alone
module apt_timer (
  input  wire  logic        mclk,
  input  wire  logic        rst,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire  logic        crystalOscIn,
  input  wire  logic        deepWake,
  output logic              compareOutputPin,
  output logic              compareOutputActive,
  output logic              wakeRequest
);
  import apt_pkg::*;

  // ==========================================================================
  // decoding helpers
  function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
    regHit = (a == off);
  endfunction

  // prescaler terminal count for each clock select code
  function automatic logic divMatch(input logic [2:0] cs, input logic [9:0] p);
    case (cs)
      CS_1:    divMatch = 1'b1;
      CS_8:    divMatch = &p[2:0];
      CS_32:   divMatch = &p[4:0];
      CS_64:   divMatch = &p[5:0];
      CS_128:  divMatch = &p[6:0];
      CS_256:  divMatch = &p[7:0];
      CS_1024: divMatch = &p[9:0];
      default: divMatch = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // bus address phase and read data
  logic        wrPend_ff, nxt_wrPend;
  logic [7:0]  wrAddr_ff, nxt_wrAddr;
  logic [31:0] rdata_ff,  nxt_rdata;
  logic        addrTaken;

  // ==========================================================================
  // timer state
  apt_ctrl_s   ctrl_ff,     nxt_ctrl;
  logic [7:0]  count_ff,    nxt_count;
  logic [7:0]  compare_ff,  nxt_compare;
  logic [7:0]  cmpBuf_ff,   nxt_cmpBuf;
  apt_dir_e    dir_ff,      nxt_dir;
  logic        pwmHigh_ff,  nxt_pwmHigh;
  logic [1:0]  flags_ff,    nxt_flags;
  logic        async_ff,    nxt_async;
  logic [7:0]  hold_ff [3];
  logic [7:0]  nxt_hold [3];
  logic [2:0]  busy_ff,     nxt_busy;
  logic [1:0]  edges_ff [3];
  logic [1:0]  nxt_edges [3];
  logic [7:0]  readCopy_ff, nxt_readCopy;
  logic [1:0]  pipe_ff [FLAG_SYNC_CYC];
  logic [1:0]  nxt_pipe [FLAG_SYNC_CYC];
  logic [9:0]  pre_ff,      nxt_pre;
  logic        wakePend_ff, nxt_wakePend;
  logic        armed_ff,    nxt_armed;
  logic        wake_ff,     nxt_wake;
  logic        xtalMeta_ff, xtalSync_ff, xtalPrev_ff;

  logic        xtalRise;
  logic        srcTick;
  logic        tick;
  logic [2:0]  commit;
  logic [7:0]  wrByte;
  logic [7:0]  nc;
  logic        match;
  logic        ovfEv;
  logic        cmpEv;
  logic [1:0]  delivered;
  logic [1:0]  w1c;

  // ==========================================================================
  // bus slave: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign addrTaken = hsel && hready && htrans[1];
  assign wrByte    = hwdata[7:0];

  // address phase capture and read data staging
  always_comb begin
    nxt_wrPend = addrTaken && hwrite;
    nxt_wrAddr = haddr[7:0];
    nxt_rdata  = rdata_ff;
    if (addrTaken && !hwrite) begin
      nxt_rdata = 32'h0000_0000;
      case (haddr[7:0])
        OFF_CONTROL: nxt_rdata[7:0] = {1'b0, ctrl_ff[6:0]};
        OFF_COUNT:   nxt_rdata[7:0] = async_ff ? readCopy_ff : count_ff;
        OFF_COMPARE: nxt_rdata[7:0] = compare_ff;
        OFF_ASYNC: begin
          nxt_rdata[BIT_ASYNC_SEL]  = async_ff;
          nxt_rdata[BIT_COUNT_BUSY] = busy_ff[HOLD_COUNT];
          nxt_rdata[BIT_CMP_BUSY]   = busy_ff[HOLD_CMP];
          nxt_rdata[BIT_CTRL_BUSY]  = busy_ff[HOLD_CTRL];
        end
        OFF_FLAGS:   nxt_rdata[1:0] = flags_ff;
        default:     nxt_rdata = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      wrPend_ff <= nxt_wrPend;
      wrAddr_ff <= nxt_wrAddr;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ==========================================================================
  // crystal input: two-stage synchroniser, then rising-edge detect
  always_ff @(posedge mclk) begin
    if (rst) begin
      xtalMeta_ff <= 1'b0;
      xtalSync_ff <= 1'b0;
      xtalPrev_ff <= 1'b0;
    end else begin
      xtalMeta_ff <= crystalOscIn;
      xtalSync_ff <= xtalMeta_ff;
      xtalPrev_ff <= xtalSync_ff;
    end
  end

  assign xtalRise = xtalSync_ff && !xtalPrev_ff;

  // ==========================================================================
  // clock source and prescaler: the tick is an enable on mclk
  assign srcTick = async_ff ? xtalRise : 1'b1;
  assign tick    = srcTick && divMatch(ctrl_ff.cs, pre_ff);

  // ==========================================================================
  // holding stages: each counts its own crystal edges, then commits
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxt_edges[i] = edges_ff[i];
      nxt_busy[i]  = busy_ff[i];
      commit[i]    = 1'b0;
      if (busy_ff[i] && xtalRise) begin
        if (edges_ff[i] == XFER_EDGES - 2'h1) begin
          commit[i]    = 1'b1;
          nxt_busy[i]  = 1'b0;
          nxt_edges[i] = 2'h0;
        end else begin
          nxt_edges[i] = edges_ff[i] + 2'h1;
        end
      end
    end
  end

  // ==========================================================================
  // counter, compare unit, output level, flags and software writes
  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_count    = count_ff;
    nxt_compare  = compare_ff;
    nxt_cmpBuf   = cmpBuf_ff;
    nxt_dir      = dir_ff;
    nxt_pwmHigh  = pwmHigh_ff;
    nxt_async    = async_ff;
    nxt_hold     = hold_ff;
    nxt_readCopy = readCopy_ff;
    nxt_pre      = srcTick ? pre_ff + 10'h001 : pre_ff;
    nc           = count_ff;
    match        = 1'b0;
    ovfEv        = 1'b0;
    cmpEv        = 1'b0;
    w1c          = 2'b00;

    // dual-slope count with a single tick held at each end
    if (tick && {ctrl_ff.wgm1, ctrl_ff.wgm0} == WGM_PHASE_COR) begin
      if (dir_ff == DIR_UP) begin
        nc = count_ff + 8'h01;
        if (nc == CNT_MAX) begin
          nxt_dir = DIR_DOWN;
        end
      end else begin
        nc = count_ff - 8'h01;
        if (nc == CNT_BOTTOM) begin
          nxt_dir = DIR_UP;
        end
      end
      nxt_count = nc;
      if (nc == CNT_MAX) begin
        nxt_cmpBuf = compare_ff;
      end
      ovfEv = (nc == CNT_BOTTOM);
      // compare disabled while a count or compare transfer waits
      match = (nc == nxt_cmpBuf) && !busy_ff[HOLD_CMP] && !busy_ff[HOLD_COUNT];
      cmpEv = match;
      if (ctrl_ff.com == COM_OFF) begin
        nxt_pwmHigh = pwmHigh_ff;
      end else if (nc == CNT_MAX) begin
        // at MAX force the up-match level unless compare sits at MAX
        nxt_pwmHigh = (nxt_cmpBuf == CNT_MAX);
      end else if (match && dir_ff == DIR_UP) begin
        nxt_pwmHigh = 1'b0;
      end else if (match) begin
        nxt_pwmHigh = (nxt_cmpBuf != CNT_BOTTOM);
      end
    end

    // holding stage commits
    if (commit[HOLD_CTRL]) begin
      nxt_ctrl = apt_ctrl_s'({1'b0, hold_ff[HOLD_CTRL][6:0]});
    end
    if (commit[HOLD_CMP]) begin
      nxt_compare = hold_ff[HOLD_CMP];
    end
    if (commit[HOLD_COUNT]) begin
      nxt_count = hold_ff[HOLD_COUNT];
    end

    // counter copy for reads follows every crystal edge, commits included
    if (xtalRise) begin
      nxt_readCopy = nxt_count;
    end

    // software writes in the data phase
    if (wrPend_ff) begin
      if (regHit(wrAddr_ff, OFF_CONTROL)) begin
        if (async_ff) begin
          nxt_hold[HOLD_CTRL] = wrByte;
        end else begin
          nxt_ctrl = apt_ctrl_s'({1'b0, wrByte[6:0]});
        end
      end
      if (regHit(wrAddr_ff, OFF_COMPARE)) begin
        if (async_ff) begin
          nxt_hold[HOLD_CMP] = wrByte;
        end else begin
          nxt_compare = wrByte;
        end
      end
      if (regHit(wrAddr_ff, OFF_COUNT)) begin
        if (async_ff) begin
          nxt_hold[HOLD_COUNT] = wrByte;
        end else begin
          nxt_count = wrByte;
        end
      end
      if (regHit(wrAddr_ff, OFF_ASYNC)) begin
        nxt_async = wrByte[BIT_ASYNC_SEL];
      end
      if (regHit(wrAddr_ff, OFF_FLAGS)) begin
        w1c = wrByte[1:0];
      end
    end
  end

  // a write in async mode arms its holding stage (overrides the stage counter)
  logic [2:0] arm;
  always_comb begin
    arm = 3'b000;
    if (wrPend_ff && async_ff) begin
      arm[HOLD_CTRL]  = regHit(wrAddr_ff, OFF_CONTROL);
      arm[HOLD_CMP]   = regHit(wrAddr_ff, OFF_COMPARE);
      arm[HOLD_COUNT] = regHit(wrAddr_ff, OFF_COUNT);
    end
  end

  // ==========================================================================
  // flag delivery: async events pass a three-cycle pipe first
  always_comb begin
    nxt_pipe[0] = {cmpEv, ovfEv};
    for (int i = 1; i < FLAG_SYNC_CYC; i++) begin
      nxt_pipe[i] = pipe_ff[i-1];
    end
  end

  assign delivered = async_ff ? pipe_ff[FLAG_SYNC_CYC-1] : {cmpEv, ovfEv};
  assign nxt_flags = (flags_ff & ~w1c) | delivered;  // set wins over clear

  // ==========================================================================
  // wake request: starts on the next tick, rearms after a crystal edge
  always_comb begin
    nxt_wakePend = wakePend_ff || (|delivered);
    nxt_armed    = armed_ff || xtalRise;
    nxt_wake     = 1'b0;
    if (wakePend_ff && armed_ff && tick) begin
      nxt_wake     = 1'b1;
      nxt_wakePend = |delivered;
      nxt_armed    = 1'b0;
    end
  end

  // ==========================================================================
  // register all timer state; deep wake restores defaults
  always_ff @(posedge mclk) begin
    if (rst || deepWake) begin
      ctrl_ff     <= apt_ctrl_s'(RST_BYTE);
      count_ff    <= RST_BYTE;
      compare_ff  <= RST_BYTE;
      cmpBuf_ff   <= RST_BYTE;
      dir_ff      <= DIR_UP;
      pwmHigh_ff  <= 1'b0;
      flags_ff    <= 2'b00;
      async_ff    <= 1'b0;
      busy_ff     <= 3'b000;
      readCopy_ff <= RST_BYTE;
      pre_ff      <= 10'h000;
      wakePend_ff <= 1'b0;
      armed_ff    <= 1'b1;
      wake_ff     <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        hold_ff[i]  <= RST_BYTE;
        edges_ff[i] <= 2'h0;
      end
      for (int i = 0; i < FLAG_SYNC_CYC; i++) begin
        pipe_ff[i] <= 2'b00;
      end
    end else begin
      ctrl_ff     <= nxt_ctrl;
      count_ff    <= nxt_count;
      compare_ff  <= nxt_compare;
      cmpBuf_ff   <= nxt_cmpBuf;
      dir_ff      <= nxt_dir;
      pwmHigh_ff  <= nxt_pwmHigh;
      flags_ff    <= nxt_flags;
      async_ff    <= nxt_async;
      busy_ff     <= nxt_busy | arm;
      readCopy_ff <= nxt_readCopy;
      pre_ff      <= nxt_pre;
      wakePend_ff <= nxt_wakePend;
      armed_ff    <= nxt_armed;
      wake_ff     <= nxt_wake;
      for (int i = 0; i < 3; i++) begin
        hold_ff[i]  <= nxt_hold[i];
        edges_ff[i] <= arm[i] ? 2'h0 : nxt_edges[i];
      end
      for (int i = 0; i < FLAG_SYNC_CYC; i++) begin
        pipe_ff[i] <= nxt_pipe[i];
      end
    end
  end

  // ==========================================================================
  // pin drive straight from the timer-tick level, no resync
  assign compareOutputActive = (ctrl_ff.com != COM_OFF);
  assign compareOutputPin    = (ctrl_ff.com == COM_INV) ? !pwmHigh_ff : pwmHigh_ff;
  assign wakeRequest         = wake_ff;

endmodule // apt_timer

`default_nettype wire

// File: sim/apt_timer_properties.sv
// Purpose: port-level properties of the phase-correct PWM timer
// Assumes: one mclk domain, synchronous active-high rst
// Notes:   bound to apt_timer from the bench top file
`timescale 1ns/1ps
`default_nettype none
module apt_timer_properties (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        deepWake,
  input wire logic        compareOutputPin,
  input wire logic        compareOutputActive,
  input wire logic        wakeRequest
);
  // ==========================================================================
  // clocking
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // bus side
  // slave never stalls and always answers okay
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus stall or error");

  // registers are one byte wide
  property p_byte_data;
    hrdata[31:8] == 24'h0;
  endproperty
  a_byte_data: assert property (p_byte_data) else $error("upper read bits set");

  // read data moves only after a read is taken
  property p_data_holds;
    !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata);
  endproperty
  a_data_holds: assert property (p_data_holds) else $error("read data moved");

  // bus outputs are quiet on leaving reset
  property p_rst_bus;
    $past(rst) |-> hrdata == 32'h0 && hreadyout;
  endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus not quiet after reset");

  // ==========================================================================
  // pin side
  // pins are quiet on leaving reset
  property p_rst_pins;
    $past(rst) |-> !compareOutputPin && !compareOutputActive && !wakeRequest;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not quiet after reset");

  // wake input returns the timer to defaults
  property p_deep_wake;
    $rose(deepWake) |=> !compareOutputActive ##1 !compareOutputActive && !compareOutputPin;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("wake kept state");

  // wake request is a single pulse
  property p_wake_pulse;
    wakeRequest |=> !wakeRequest;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");

  // released output takes no compare action
  property p_off_quiet;
    !compareOutputActive && !$past(compareOutputActive) && !$past(deepWake)
      |-> $stable(compareOutputPin);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("released pin moved");
endmodule // apt_timer_properties
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: self-checking bench for the phase-correct PWM timer
// Assumes: single word AHB-Lite transfers, 200 MHz mclk
// Notes:   crystal input is a free square wave of twelve mclk
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import apt_pkg::*;
  logic        mclk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        crystalOscIn = 1'b0;
  logic        deepWake;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        compareOutputPin;
  logic        compareOutputActive;
  logic        wakeRequest;
  int          errors;
  int          num_checks;
  int          xcnt = 0;
  int          cyc = 0;
  int          wakes = 0;

  // ==========================================================================
  // device
  apt_timer i_dut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .crystalOscIn(crystalOscIn), .deepWake(deepWake),
    .compareOutputPin(compareOutputPin),
    .compareOutputActive(compareOutputActive), .wakeRequest(wakeRequest)
  );

  // ==========================================================================
  // clocks
  // system clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // crystal at one twelfth of mclk, cycle counter
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    xcnt <= (xcnt == 5) ? 0 : xcnt + 1;
    if (xcnt == 5) crystalOscIn <= ~crystalOscIn;
    if (wakeRequest) wakes <= wakes + 1;
  end

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one single transfer: address phase, then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rdv);
    int n;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 128);
    rdv = hrdata;
    if (n >= 128) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, {24'h0, d}, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(a, 1'b0, 32'h0, d);
  endtask

  // cycles until the pin leaves a level
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (compareOutputPin === lvl && n < 40000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 40000) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic settle(output logic [31:0] a);
    a = 32'h7;
    for (int i = 0; i < 40 && a[2:0] !== 3'h0; i++) rd(OFF_ASYNC, a);
    check("busy clear", a[2:0], 3'h0);
  endtask

  // ==========================================================================
  // scenarios
  // reset values and an unmapped place
  task automatic check_reset;
    logic [31:0] a;
    wr(8'h14, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), a);
      check("reset or unmapped", a, 32'h0);
    end
  endtask

  // one full low and high span of the waveform
  task automatic shape(input logic [7:0] ctrl, input int lo, input int hi);
    int a;
    int b;
    wr(OFF_CONTROL, ctrl);
    #1;
    span(1'b0, a);
    span(1'b1, a);
    span(1'b0, a);
    span(1'b1, b);
    check("low span", a, lo);
    check("high span", b, hi);
  endtask

  task automatic run_pwm;
    logic [2:0] cs [3];
    int         nf [3];
    int         lo;
    cs = '{CS_1, CS_8, CS_32};
    nf = '{1, 8, 32};
    wr(OFF_COMPARE, 8'h40);
    for (int i = 0; i < 3; i++) begin
      lo = 2 * (int'(CNT_MAX) - 'h40) * nf[i];
      shape({2'b01, COM_NONINV, 1'b0, cs[i]}, lo, 510 * nf[i] - lo);
    end
    shape({2'b01, COM_INV, 1'b0, CS_1}, 2 * 'h40, 510 - 2 * 'h40);
  endtask

  // extreme compare values give a flat output
  task automatic check_flat;
    logic [7:0] cv  [4];
    logic [1:0] cm  [4];
    logic       lvl [4];
    int         bad;
    cv  = '{8'h00, 8'hFF, 8'h00, 8'hFF};
    cm  = '{COM_NONINV, COM_NONINV, COM_INV, COM_INV};
    lvl = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(OFF_COMPARE, cv[i]);
      wr(OFF_CONTROL, {2'b01, cm[i], 1'b0, CS_1});
      repeat (1100) @(posedge mclk);
      bad = 0;
      repeat (520) begin
        #1;
        if (compareOutputPin !== lvl[i]) bad++;
        @(posedge mclk);
      end
      check("flat output", bad, 0);
    end
  endtask

  // flags, clearing, stopped counter
  task automatic check_flags;
    logic [31:0] a;
    logic [31:0] b;
    rd(OFF_FLAGS, a);
    check("events seen", a, 32'h3);
    wr(OFF_COMPARE, 8'h40);
    wr(OFF_CONTROL, 8'h41);
    #1;
    b = {31'h0, compareOutputPin};
    repeat (520) @(posedge mclk);
    check("pin held", {31'h0, compareOutputPin}, b);
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_FLAGS, 8'h03);
    rd(OFF_FLAGS, a);
    check("flags cleared", a, 32'h0);
    check("pin released", compareOutputActive, 1'b0);
    rd(OFF_COUNT, a);
    rd(OFF_COUNT, b);
    check("stopped count", b, a);
  endtask

  // crystal clocking with holding stages, then wake defaults
  task automatic check_async;
    logic [31:0] a;
    int          t;
    wr(OFF_ASYNC, 8'h08);
    t = cyc;
    wr(OFF_COMPARE, 8'h10);
    rd(OFF_ASYNC, a);
    check("compare busy", a, 32'h0A);
    wr(OFF_COUNT, 8'h20);
    rd(OFF_ASYNC, a);
    check("both busy", a, 32'h0E);
    settle(a);
    check("busy time", 32'(cyc - t >= 12 && cyc - t <= 48), 32'h1);
    rd(OFF_COMPARE, a);
    check("compare landed", a, 32'h10);
    rd(OFF_COUNT, a);
    check("count copy", a, 32'h20);
    wr(OFF_CONTROL, 8'h61);
    settle(a);
    check("pin driven", compareOutputActive, 1'b1);
    wr(OFF_FLAGS, 8'h03);
    t = wakes;
    a = 32'h0;
    for (int i = 0; i < 5000 && a[1] !== 1'b1; i++) rd(OFF_FLAGS, a);
    check("async match", a[1], 1'b1);
    repeat (40) @(posedge mclk);
    check("wake pulse", 32'(wakes > t), 32'h1);
    deepWake <= 1'b1;
    @(posedge mclk);
    deepWake <= 1'b0;
    rd(OFF_CONTROL, a);
    check("wake control", a, 32'h0);
    rd(OFF_ASYNC, a);
    check("wake status", a, 32'h0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    deepWake = 1'b0;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check_reset();
    run_pwm();
    check_flat();
    check_flags();
    check_async();
    complete_run();
  end
endmodule // tb_top

bind apt_timer apt_timer_properties i_props (
  .mclk(mclk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .deepWake(deepWake), .compareOutputPin(compareOutputPin),
  .compareOutputActive(compareOutputActive), .wakeRequest(wakeRequest)
);
`default_nettype wire
